// ### rtl/wdt_params.svh
/*
  Constants of the software watchdog: register offsets, bit positions,
  reset values and cycle counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define WDT_ADDR_W 4
`define WDT_OFS_EC0 4'h0
`define WDT_OFS_EC1 4'h1
`define WDT_OFS_PRIO 4'h2
`define WDT_OFS_REL 4'h3
`define WDT_OFS_CNTL 4'h4
`define WDT_OFS_CNTH 4'h5
`define WDT_OFS_STAT 4'h6
`define WDT_OFS_MASK 4'h7

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define WDT_CTRL_BIT 6
`define WDT_PSEL_BIT 7
`define WDT_RST_BYTE 8'h00
`define WDT_RST_CNT 16'h0000
`define WDT_TIMEOUT_VAL 16'h7CFF
`define WDT_IRQ_W 3
`define WDT_IRQ_TMO 0
`define WDT_IRQ_RFR 1
`define WDT_IRQ_LAPSE 2

// ------------------------------------------------------------
// timing counts in clock cycles, except WDT_PS16_LAST, which counts half-rate prescaler ticks
// ------------------------------------------------------------
`define WDT_FLAG_HOLD 4'hC
`define WDT_MC_LAST 4'hB
`define WDT_PS16_LAST 4'hF
`define WDT_FAST_PER 24
`define WDT_SLOW_PER 384

`endif

// ### rtl/wdt_pkg.sv
/*
  Types of the software watchdog: register bus request and run state.
  Assumes wdt_params.svh is on the include path.
*/
`default_nettype none
`include "wdt_params.svh"

package wdt_pkg;

  typedef struct packed {
    logic [`WDT_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } run_state_t;

endpackage

`default_nettype wire

// ### rtl/software_watchdog_timer.sv
/*
  Software watchdog timer with its register port and interrupt.
  Assumes a single clock, an asynchronous active-low system reset, and a
  master that issues one-cycle read or write strobes.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module software_watchdog_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire wdt_pkg::bus_req_t bus_req,
  output var logic [7:0] rdata,
  output var logic timeout_status,
  output var logic reset_request,
  output var logic irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic wr_hit(input wdt_pkg::bus_req_t r,
                                  input logic [`WDT_ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [3:0] hold_nxt(input logic set,
                                          input logic [3:0] cnt);
    logic [3:0] res;
    res = cnt;
    if (set) begin
      res = `WDT_FLAG_HOLD;
    end else if (cnt != 4'h0) begin
      res = cnt - 4'h1;
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  wdt_pkg::run_state_t st_r, st_nxt;
  logic [7:0] ec0_r, ec1_r, prio_r, rel_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0] arm_cnt_r, start_cnt_r;
  logic [3:0] mc_r, ps16_r;
  logic div2_r;
  logic tmo_r;
  logic [`WDT_IRQ_W-1:0] stat_r, stat_nxt, mask_r;
  logic irq_r;
  logic [7:0] rdata_r;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_ec0 = wr_hit(bus_req, `WDT_OFS_EC0);
  wire wr_ec1 = wr_hit(bus_req, `WDT_OFS_EC1);
  wire wr_prio = wr_hit(bus_req, `WDT_OFS_PRIO);
  wire wr_rel = wr_hit(bus_req, `WDT_OFS_REL);
  wire wr_mask = wr_hit(bus_req, `WDT_OFS_MASK);
  wire rd_stat = bus_req.rd && (bus_req.addr == `WDT_OFS_STAT);
  wire arm_r = ec0_r[`WDT_CTRL_BIT];
  wire start_r = ec1_r[`WDT_CTRL_BIT];
  wire arm_set = wr_ec0 && bus_req.wdata[`WDT_CTRL_BIT];
  wire start_set = wr_ec1 && bus_req.wdata[`WDT_CTRL_BIT];
  wire refresh = start_set && arm_r;
  wire arm_exp = arm_r && (arm_cnt_r == 4'h1) && !arm_set;
  wire start_exp = start_r && (start_cnt_r == 4'h1) && !start_set;
  wire lapse = arm_exp && !refresh;
  wire psel = rel_r[`WDT_PSEL_BIT];
  wire running = (st_r == wdt_pkg::ST_RUN);

  // ------------------------------------------------------------
  // prescalers
  // ------------------------------------------------------------
  wire mc_tick = (mc_r == `WDT_MC_LAST);
  wire half_tick = mc_tick && div2_r;
  wire slow_tick = half_tick && (ps16_r == `WDT_PS16_LAST);
  wire tick = psel ? slow_tick : half_tick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mc_r <= 4'h0;
      div2_r <= 1'b0;
      ps16_r <= 4'h0;
    end else if (running) begin
      mc_r <= mc_tick ? 4'h0 : mc_r + 4'h1;
      div2_r <= div2_r ^ mc_tick;
      ps16_r <= half_tick ? ps16_r + 4'h1 : ps16_r;
    end
  end

  // ------------------------------------------------------------
  // run state and counter
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      wdt_pkg::ST_IDLE: begin
        if (start_set) begin
          st_nxt = wdt_pkg::ST_RUN;
        end
      end
      wdt_pkg::ST_RUN: begin
        st_nxt = wdt_pkg::ST_RUN;
      end
      default: begin
        st_nxt = wdt_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (refresh) begin
      cnt_nxt = {1'b0, rel_r[6:0], 8'h00};
    end else if (running && tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  wire tmo_nxt = (cnt_nxt == `WDT_TIMEOUT_VAL);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= wdt_pkg::ST_IDLE;
      cnt_r <= `WDT_RST_CNT;
      tmo_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  wire arm_nxt = arm_set || (arm_r && !refresh && !arm_exp);
  wire start_nxt = start_set || (start_r && !start_exp);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ec0_r <= `WDT_RST_BYTE;
      ec1_r <= `WDT_RST_BYTE;
      prio_r <= `WDT_RST_BYTE;
      rel_r <= `WDT_RST_BYTE;
      arm_cnt_r <= 4'h0;
      start_cnt_r <= 4'h0;
      mask_r <= '0;
    end else begin
      if (wr_ec0) begin
        ec0_r <= bus_req.wdata;
      end
      ec0_r[`WDT_CTRL_BIT] <= arm_nxt;
      if (wr_ec1) begin
        ec1_r <= bus_req.wdata;
      end
      ec1_r[`WDT_CTRL_BIT] <= start_nxt;
      if (wr_prio) begin
        prio_r <= bus_req.wdata;
      end
      if (wr_rel) begin
        rel_r <= bus_req.wdata;
      end
      if (wr_mask) begin
        mask_r <= bus_req.wdata[`WDT_IRQ_W-1:0];
      end
      arm_cnt_r <= refresh ? 4'h0 : hold_nxt(arm_set, arm_cnt_r);
      start_cnt_r <= hold_nxt(start_set, start_cnt_r);
    end
  end

  // ------------------------------------------------------------
  // interrupt status, read clears, set wins
  // ------------------------------------------------------------
  wire [`WDT_IRQ_W-1:0] ev;
  assign ev[`WDT_IRQ_TMO] = tmo_nxt && !tmo_r;
  assign ev[`WDT_IRQ_RFR] = refresh;
  assign ev[`WDT_IRQ_LAPSE] = lapse;

  always_comb begin
    stat_nxt = (rd_stat ? '0 : stat_r) | ev;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [7:0] prio_view, rd_mux;

  always_comb begin
    prio_view = prio_r;
    prio_view[`WDT_CTRL_BIT] = tmo_r;
    unique case (bus_req.addr)
      `WDT_OFS_EC0: rd_mux = ec0_r;
      `WDT_OFS_EC1: rd_mux = ec1_r;
      `WDT_OFS_PRIO: rd_mux = prio_view;
      `WDT_OFS_REL: rd_mux = rel_r;
      `WDT_OFS_CNTL: rd_mux = cnt_r[7:0];
      `WDT_OFS_CNTH: rd_mux = cnt_r[15:8];
      `WDT_OFS_STAT: rd_mux = {5'h00, stat_r};
      `WDT_OFS_MASK: rd_mux = {5'h00, mask_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign timeout_status = tmo_r;
  assign reset_request = tmo_r;
  assign irq = irq_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [8:0] gap_r;
  logic gap_ok_r;
  logic psel_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 9'h000;
      gap_ok_r <= 1'b0;
      psel_q <= 1'b0;
    end else begin
      psel_q <= psel;
      gap_r <= (running && tick) ? 9'h000 : gap_r + 9'h001;
      if (psel != psel_q) begin
        gap_ok_r <= 1'b0;
      end else if (running && tick) begin
        gap_ok_r <= 1'b1;
      end
    end
  end

  property p_fast_rate;
    running && tick && gap_ok_r && !psel && (psel == psel_q)
      |-> gap_r == 9'(`WDT_FAST_PER - 1);
  endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("fast rate wrong");

  property p_slow_rate;
    running && tick && gap_ok_r && psel && (psel == psel_q)
      |-> gap_r == 9'(`WDT_SLOW_PER - 1);
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow rate wrong");

  property p_advance;
    running && tick && !refresh |=> cnt_r == $past(cnt_r) + 16'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance by one");

  property p_keep_run;
    running |=> running;
  endproperty
  a_keep_run: assert property (p_keep_run) else $error("watchdog stopped");

  property p_start;
    !running && start_set |=> running ##1 running;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  property p_idle_hold;
    !running && !refresh |=> cnt_r == $past(cnt_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle counter moved");

  property p_tmo_set;
    cnt_r == `WDT_TIMEOUT_VAL |-> timeout_status && reset_request;
  endproperty
  a_tmo_set: assert property (p_tmo_set) else $error("timeout not flagged");

  property p_tmo_clr;
    timeout_status ##1 (cnt_r != `WDT_TIMEOUT_VAL) |-> !timeout_status;
  endproperty
  a_tmo_clr: assert property (p_tmo_clr) else $error("timeout stuck");

  property p_refresh;
    arm_r && start_set |=> cnt_r == {1'b0, $past(rel_r[6:0]), 8'h00} && !arm_r;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh wrong");

  property p_arm_life;
    !arm_r && arm_set ##1 (!start_set && !arm_set)[*8] |-> arm_r;
  endproperty
  a_arm_life: assert property (p_arm_life) else $error("arm cleared early");

  property p_arm_end;
    arm_r && arm_cnt_r == 4'h1 && !arm_set |=> !arm_r;
  endproperty
  a_arm_end: assert property (p_arm_end) else $error("arm not cleared");

  property p_start_life;
    !start_r && start_set |=> start_r [*8];
  endproperty
  a_start_life: assert property (p_start_life) else $error("start cleared early");

  property p_start_end;
    start_r && start_cnt_r == 4'h1 && !start_set |=> !start_r;
  endproperty
  a_start_end: assert property (p_start_end) else $error("start not cleared");

  property p_rel_back;
    wr_rel ##1 (bus_req.rd && bus_req.addr == `WDT_OFS_REL && !wr_rel)
      |=> rdata == $past(bus_req.wdata, 2);
  endproperty
  a_rel_back: assert property (p_rel_back) else $error("reload readback");

  property p_irq;
    stat_r[`WDT_IRQ_TMO] && mask_r[`WDT_IRQ_TMO] && !rd_stat |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  c_refresh: cover property (arm_r && start_set);
  c_lapse: cover property (lapse);
  c_timeout: cover property ($rose(timeout_status));
  c_slow: cover property (running && psel && tick);

endmodule

`default_nettype wire

// ### sim/sys_reset_model.sv
/*
  Model of the system reset logic that faces the watchdog's reset request.
  Assumes the watchdog's clock and its asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module sys_reset_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_request,
  output var logic [7:0] reset_count
);
  // ----------------------------------------
  // request edge counter
  // ----------------------------------------
  logic req_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
      reset_count <= 8'h00;
    end else begin
      req_r <= reset_request;
      if (reset_request && !req_r) begin
        reset_count <= reset_count + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ### sim/software_watchdog_timer_bench.sv
/*
  Self-checking bench of the software watchdog timer.
  Assumes the design files and wdt_params.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module software_watchdog_timer_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  wdt_pkg::bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic timeout_status;
  logic reset_request;
  logic irq;
  logic [7:0] reset_count;
  logic [7:0] v;
  logic [7:0] rel;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 7053;
  int t1;
  int n;

  software_watchdog_timer u_software_watchdog_timer (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .rdata(rdata), .timeout_status(timeout_status), .reset_request(reset_request), .irq(irq));
  sys_reset_model u_sys_reset_model (.clock(clock), .rst_n(rst_n), .reset_request(reset_request),
    .reset_count(reset_count));

  // ----------------------------------------
  // clock, cycle count, hang limit
  // ----------------------------------------
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // bus cycles and compares
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clock);
    bus_req <= '{a, d, w, ~w};
    @(posedge clock);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string what);
    bus(a, 8'h00, 1'b0);
    chk({8'h00, v}, {8'h00, exp}, what);
  endtask
  task automatic next_tick();
    logic [7:0] old;
    bus(`WDT_OFS_CNTL, 8'h00, 1'b0);
    old = v;
    n = 0;
    while (v === old && n < 400) begin
      bus(`WDT_OFS_CNTL, 8'h00, 1'b0);
      n++;
    end
  endtask
  task automatic period(input int exp);
    next_tick();
    t1 = cyc;
    next_tick();
    chk(16'(cyc - t1), 16'(exp), "tick period");
  endtask
  task automatic refresh(input logic [7:0] r);
    wr(`WDT_OFS_REL, r);
    wr(`WDT_OFS_EC0, 8'h40);
    wr(`WDT_OFS_EC1, 8'h40);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rc(i[3:0], 8'h00, "reset value");
    $display("test reset values done");
    rel = 8'($random(seed));
    wr(`WDT_OFS_REL, rel);
    rc(`WDT_OFS_REL, rel, "reload readback");
    wr(`WDT_OFS_CNTL, 8'hFF);
    rc(`WDT_OFS_CNTL, 8'h00, "counter read-only");
    wr(`WDT_OFS_PRIO, 8'hFF);
    rc(`WDT_OFS_PRIO, 8'hBF, "priority bit6 read-only");
    wr(`WDT_OFS_PRIO, 8'h00);
    wr(`WDT_OFS_MASK, 8'h05);
    wr(`WDT_OFS_EC0, 8'h40);
    rc(`WDT_OFS_EC0, 8'h40, "arm set");
    repeat (9) @(posedge clock);
    rc(`WDT_OFS_EC0, 8'h00, "arm lapsed");
    rc(`WDT_OFS_CNTH, 8'h00, "idle after lapse");
    chk({15'h0, irq}, 16'h0001, "lapse irq");
    rc(`WDT_OFS_STAT, 8'h04, "lapse status");
    repeat (2) @(posedge clock);
    chk({15'h0, irq}, 16'h0000, "irq cleared");
    $display("test arm lapse done");
    // keep the random reload but select the fast prescaler
    wr(`WDT_OFS_REL, rel & 8'h7F);
    wr(`WDT_OFS_EC1, 8'h40);
    rc(`WDT_OFS_EC1, 8'h40, "start flag");
    period(`WDT_FAST_PER);
    repeat (12) @(posedge clock);
    rc(`WDT_OFS_EC1, 8'h00, "start flag cleared");
    wr(`WDT_OFS_EC1, 8'h00);
    period(`WDT_FAST_PER);
    $display("test start done");
    refresh(8'h7C);
    rc(`WDT_OFS_CNTL, 8'h00, "low byte cleared");
    rc(`WDT_OFS_CNTH, 8'h7C, "high byte loaded");
    rc(`WDT_OFS_EC0, 8'h00, "arm cleared by refresh");
    chk({15'h0, irq}, 16'h0000, "masked refresh irq");
    rc(`WDT_OFS_STAT, 8'h02, "refresh status");
    refresh(8'hFC);
    period(`WDT_SLOW_PER);
    $display("test refresh and prescaler done");
    refresh(8'h7C);
    n = 0;
    while (timeout_status !== 1'b1 && n < 7000) begin
      @(posedge clock);
      n++;
    end
    rc(`WDT_OFS_CNTH, 8'h7C, "timeout high byte");
    rc(`WDT_OFS_CNTL, 8'hFF, "timeout low byte");
    rc(`WDT_OFS_PRIO, 8'h40, "priority bit");
    chk({15'h0, reset_request}, 16'h0001, "reset request");
    chk({15'h0, irq}, 16'h0001, "timeout irq");
    rc(`WDT_OFS_STAT, 8'h03, "timeout status bits");
    repeat (30) @(posedge clock);
    chk({15'h0, timeout_status}, 16'h0000, "timeout cleared");
    rc(`WDT_OFS_PRIO, 8'h00, "priority bit cleared");
    chk({8'h0, reset_count}, 16'h0001, "one reset request");
    $display("test timeout done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk({14'h0, timeout_status, reset_request}, 16'h0000, "outputs in reset");
    rst_n <= 1'b1;
    rc(`WDT_OFS_REL, 8'h00, "reload after reset");
    repeat (30) @(posedge clock);
    rc(`WDT_OFS_CNTL, 8'h00, "idle after reset");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
